/* File: core/gpc_pkg.sv */
// constants, pin bundle and state types for the gain and power control port
//
// What this block does
// - serial port and parallel latch operate only while enable input is high
// - serial transaction open while select latch low
// - latch rising edge captures parallel gain bits
// - serial data sampled on serial clock rise
// - serial bits shift into eight-bit register
// - serial output driven only during read transactions
// - parallel select high silences the serial port
// - parallel select high takes gain from pins
// - parallel select low gives serial port control
// - low power pin low: serial power setting
// - low power pin high forces reduced power
// - gain in 0.5 dB steps, 15.5 dB span
// - reduced power selectable by low power pin
package gpc_pkg;

  localparam int        SHIFT_W        = 8;
  localparam int        GAIN_W         = 5;
  localparam int        CNT_W          = 3;
  localparam int        ADDR_W         = 7;
  // attenuation per code count and full span, in milli-dB
  localparam int        ATTEN_STEP_MDB = 500;
  localparam int        ATTEN_MAX_MDB  = 15500;
  localparam logic [4:0] GAIN_CODE_MAX = 5'h1f;
  // command byte layout: read flag on top, register index below
  localparam int        CMD_READ_BIT   = 7;
  // serial register indices and reset values
  localparam logic [6:0] REG_GAIN      = 7'h00;
  localparam logic [6:0] REG_POWER     = 7'h01;
  localparam logic [7:0] GAIN_RESET    = 8'h00;
  localparam logic [7:0] POWER_RESET   = 8'h00;
  localparam int        POWER_LOW_BIT  = 0;
  localparam logic [2:0] BIT_CNT_LAST  = 3'h7;
  localparam logic [2:0] BIT_CNT_RESET = 3'h0;
  localparam logic [4:0] LATCH_RESET   = 5'h00;

  // raw pins from the host controller, all asynchronous to core_clk_i
  typedef struct packed {
    logic             enable;
    logic             select_latch_n;
    logic             sclk;
    logic             sdi;
    logic             parallel_select;
    logic             low_power_select;
    logic [GAIN_W-1:0] gain_bit;
  } host_pins_t;

  localparam int PINS_W = $bits(host_pins_t);
  localparam logic [PINS_W-1:0] PINS_RESET = {2'b01, {(PINS_W-2){1'b0}}};

  typedef enum logic [1:0] {SER_IDLE, SER_CMD, SER_DATA} ser_state_t;

endpackage

/* File: core/gpc_regs.sv */
// two-entry serial register file with registered read data
`timescale 1ns/1ps
module gpc_regs
(
  input  wire logic                      core_clk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      wr_en_i,
  input  wire logic [gpc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [7:0]                wdata_i,
  output logic      [7:0]                rdata_o,
  output logic      [7:0]                gain_reg_o,
  output logic      [7:0]                power_reg_o
);
  import gpc_pkg::*;

  // writes to unmapped indices are dropped
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      gain_reg_o  <= GAIN_RESET;
      power_reg_o <= POWER_RESET;
    end
    else if (wr_en_i && addr_i == REG_GAIN)
      gain_reg_o  <= wdata_i;
    else if (wr_en_i && addr_i == REG_POWER)
      power_reg_o <= wdata_i;
  end

  // read data registered; unmapped indices read zero
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      rdata_o <= 8'h00;
    else if (addr_i == REG_GAIN)
      rdata_o <= gain_reg_o;
    else if (addr_i == REG_POWER)
      rdata_o <= power_reg_o;
    else
      rdata_o <= 8'h00;
  end

endmodule

/* File: core/gain_power_control_port.sv */
// gain and power control front end: pin sync, serial port, parallel latch
`timescale 1ns/1ps
module gain_power_control_port
(
  input  wire logic                       core_clk_i,
  input  wire logic                       resetn_i,
  input  wire gpc_pkg::host_pins_t        pins_i,
  output logic                            sdo_o,
  output logic                            sdo_oe_o,
  output logic [gpc_pkg::GAIN_W-1:0]      atten_code_o,
  output logic                            low_power_o,
  output logic                            active_o
);
  import gpc_pkg::*;

  host_pins_t             meta_q;
  host_pins_t             sync_q;
  logic                   cs_prev_q;
  logic                   sclk_prev_q;
  logic                   cs_rise;
  logic                   cs_fall;
  logic                   sclk_rise;
  logic                   sclk_fall;
  logic                   ser_ok;
  ser_state_t             state_q;
  logic [CNT_W-1:0]       cnt_q;
  logic [SHIFT_W-1:0]     shift_q;
  logic [SHIFT_W-1:0]     cmd_q;
  logic [SHIFT_W-1:0]     tx_q;
  logic                   tx_load_q;
  logic                   wr_en;
  logic [SHIFT_W-1:0]     wdata;
  logic [SHIFT_W-1:0]     rdata;
  logic [SHIFT_W-1:0]     gain_reg;
  logic [SHIFT_W-1:0]     power_reg;
  logic [GAIN_W-1:0]      par_latch_q;
  logic                   is_read;
  logic                   cmd_done_q;
  logic                   tx_arm_q;

  // next shift value: new bit enters at the bottom, msb first on the wire
  function automatic logic [SHIFT_W-1:0] shift_in(input logic [SHIFT_W-1:0] v,
                                                 input logic              b);
    shift_in = {v[SHIFT_W-2:0], b};
  endfunction

  // two-flop synchroniser on every host pin; the link clock is sampled too
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      meta_q <= host_pins_t'(PINS_RESET);
      sync_q <= host_pins_t'(PINS_RESET);
    end
    else
    begin
      meta_q <= pins_i;
      sync_q <= meta_q;
    end
  end

  // edge history taken from the second stage only
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      cs_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      cs_prev_q   <= sync_q.select_latch_n;
      sclk_prev_q <= sync_q.sclk;
    end
  end

  assign cs_rise   = sync_q.select_latch_n & ~cs_prev_q;
  assign cs_fall   = ~sync_q.select_latch_n & cs_prev_q;
  assign sclk_rise = sync_q.sclk & ~sclk_prev_q;
  assign sclk_fall = ~sync_q.sclk & sclk_prev_q;
  // serial port alive only when enabled and parallel select is low
  assign ser_ok    = sync_q.enable & ~sync_q.parallel_select;
  assign is_read   = cmd_q[CMD_READ_BIT];

  // frame state: open on latch low, closed on latch high
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      state_q <= SER_IDLE;
    else if (!ser_ok || sync_q.select_latch_n)
      state_q <= SER_IDLE;
    else
    begin
      case (state_q)
        SER_IDLE:
          if (cs_fall)
            state_q <= SER_CMD;
        SER_CMD:
          if (sclk_rise && cnt_q == BIT_CNT_LAST)
            state_q <= SER_DATA;
        SER_DATA:
          state_q <= SER_DATA;  // extra bits after the data byte are ignored
        default:
          state_q <= SER_IDLE;
      endcase
    end
  end

  // bit counter and eight-bit input shifter, sampling on clock rise
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      cnt_q   <= BIT_CNT_RESET;
      shift_q <= '0;
    end
    else if (state_q == SER_IDLE)
      cnt_q   <= BIT_CNT_RESET;
    else if (sclk_rise)
    begin
      cnt_q   <= cnt_q + 3'h1;  // wraps from seven back to zero
      shift_q <= shift_in(shift_q, sync_q.sdi);
    end
  end

  // command byte kept for the whole frame
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      cmd_q <= '0;
    else if (state_q == SER_CMD && sclk_rise && cnt_q == BIT_CNT_LAST)
      cmd_q <= shift_in(shift_q, sync_q.sdi);
  end

  // write lands on the eighth data bit; one write per frame
  assign wdata = shift_in(shift_q, sync_q.sdi);
  assign wr_en = ser_ok && !sync_q.select_latch_n && state_q == SER_DATA && !is_read
                 && sclk_rise && cnt_q == BIT_CNT_LAST && !cmd_done_q;

  // blocks a second write if the host keeps clocking past the data byte
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i || state_q != SER_DATA)
      cmd_done_q <= 1'b0;
    else if (sclk_rise && cnt_q == BIT_CNT_LAST)
      cmd_done_q <= 1'b1;
  end

  gpc_regs u_regs
  (
    .core_clk_i  (core_clk_i),
    .resetn_i    (resetn_i),
    .wr_en_i     (wr_en),
    .addr_i      (cmd_q[ADDR_W-1:0]),
    .wdata_i     (wdata),
    .rdata_o     (rdata),
    .gain_reg_o  (gain_reg),
    .power_reg_o (power_reg)
  );

  // read data loads two cycles after the command: the register file read
  // is registered, so one cycle alone would still show the old index
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      tx_arm_q  <= 1'b0;
      tx_load_q <= 1'b0;
    end
    else
    begin
      tx_arm_q  <= state_q == SER_CMD && sclk_rise && cnt_q == BIT_CNT_LAST;
      tx_load_q <= tx_arm_q;
    end
  end

  // output shifter moves on clock fall so each bit is stable at the rise
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      tx_q  <= '0;
      sdo_o <= 1'b0;
    end
    else if (tx_load_q)
      tx_q  <= rdata;
    else if (state_q == SER_DATA && is_read && sclk_fall)
    begin
      sdo_o <= tx_q[SHIFT_W-1];
      tx_q  <= {tx_q[SHIFT_W-2:0], 1'b0};
    end
  end

  // output enable only in the data phase of a read
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      sdo_oe_o <= 1'b0;
    else
      sdo_oe_o <= ser_ok && !sync_q.select_latch_n
                  && state_q == SER_DATA && is_read;
  end

  // parallel latch: pins are synced with the latch line, so they stay aligned
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      par_latch_q <= LATCH_RESET;
    else if (sync_q.enable && sync_q.parallel_select && cs_rise)
      par_latch_q <= sync_q.gain_bit;
  end

  // gain source: parallel latch or serial register, never a mix
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      atten_code_o <= LATCH_RESET;
    else if (sync_q.parallel_select)
      atten_code_o <= par_latch_q;
    else
      atten_code_o <= gain_reg[GAIN_W-1:0];
  end

  // pin forces reduced power; otherwise the serial power bit decides
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      low_power_o <= 1'b0;
    else
      low_power_o <= sync_q.low_power_select
                     | power_reg[POWER_LOW_BIT];
  end

  // device active only while enable is high
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      active_o <= 1'b0;
    else
      active_o <= sync_q.enable;
  end

  // ---- checks ----
  AST_OE_ONLY_READ: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    sdo_oe_o |-> $past(is_read) && $past(state_q) == SER_DATA)
    else $error("sdo driven outside a read data phase");

  AST_PS_SILENCES: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    sync_q.parallel_select |=> !sdo_oe_o && !wr_en)
    else $error("serial port active under parallel select");

  AST_DISABLED_IDLE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !sync_q.enable |=> state_q == SER_IDLE && !active_o)
    else $error("serial port or active flag alive while disabled");

  AST_CS_HIGH_ENDS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    sync_q.select_latch_n |=> state_q == SER_IDLE)
    else $error("frame still open with latch high");

  AST_PAR_CAPTURE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    sync_q.enable && sync_q.parallel_select && cs_rise
    ##1 sync_q.parallel_select |=> atten_code_o == $past(sync_q.gain_bit, 2))
    else $error("parallel gain not taken on latch rise");

  AST_SER_GAIN: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !sync_q.parallel_select |=> atten_code_o == $past(gain_reg[GAIN_W-1:0]))
    else $error("serial gain not applied in serial mode");

  AST_RP_FORCE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    sync_q.low_power_select |=> low_power_o)
    else $error("low power pin did not force reduced power");

  AST_RP_SERIAL: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !sync_q.low_power_select && !power_reg[POWER_LOW_BIT] |=> !low_power_o)
    else $error("reduced power without pin or serial request");

  AST_SHIFT_RISE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    state_q != SER_IDLE && sclk_rise && !sync_q.select_latch_n && ser_ok
    |=> shift_q[0] == $past(sync_q.sdi))
    else $error("input bit not shifted on clock rise");

  AST_WRITE_BYTE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    wr_en && cmd_q[ADDR_W-1:0] == REG_GAIN |=> gain_reg == $past(wdata))
    else $error("serial gain write lost");

  AST_TX_LOAD_DATA: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    tx_load_q |-> rdata == (cmd_q[ADDR_W-1:0] == REG_GAIN  ? gain_reg  :
                            cmd_q[ADDR_W-1:0] == REG_POWER ? power_reg : 8'h00))
    else $error("read data loaded from the wrong register");

  AST_ACTIVE_ON: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    sync_q.enable |=> active_o)
    else $error("device not active while enabled");

  AST_PAR_IGNORED: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !sync_q.parallel_select |=> par_latch_q == $past(par_latch_q))
    else $error("parallel latch moved in serial mode");

  AST_RP_SERIAL_ON: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    power_reg[POWER_LOW_BIT] |=> low_power_o)
    else $error("serial reduced power setting not applied");

endmodule

/* File: bench/host_model.sv */
// host controller model driving the gain port pins
`timescale 1ns/1ps
module host_model
(
  input  wire logic          core_clk_i,
  input  wire logic          sdo_i,
  output gpc_pkg::host_pins_t pins_o
);
  import gpc_pkg::*;

  // parallel gain pins start grounded for serial-only use
  initial pins_o = host_pins_t'(PINS_RESET);

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // mode pins; the pull-down pins are driven to the requested levels here
  task automatic mode(input logic en, input logic ps, input logic rp);
    @(posedge core_clk_i);
    pins_o.enable           <= en;
    pins_o.parallel_select  <= ps;
    pins_o.low_power_select <= rp;
    tick(8);
  endtask

  // 16-bit frame, msb first, data set while sclk low
  task automatic frame(input logic [15:0] w, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge core_clk_i);
    pins_o.select_latch_n <= 1'b0;
    tick(3);
    for (int i = 15; i >= 0; i--)
    begin
      pins_o.sdi <= w[i];
      tick(7);
      pins_o.sclk <= 1'b1;
      // host samples read data on the rising edge
      if (i < 8)
        rd[i] = sdo_i;
      tick(6);
      pins_o.sclk <= 1'b0;
    end
    tick(4);
    pins_o.select_latch_n <= 1'b1;
    // released data line does not keep its last value
    pins_o.sdi <= ~w[0];
    tick(5);
  endtask

  // parallel load: latch rises after pins settle
  task automatic latch_code(input logic [4:0] code);
    @(posedge core_clk_i);
    pins_o.gain_bit       <= code;
    pins_o.select_latch_n <= 1'b0;
    tick(4);
    pins_o.select_latch_n <= 1'b1;
    tick(8);
  endtask
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the gain and power control port
`timescale 1ns/1ps
module testbench;
  import gpc_pkg::*;

  typedef struct packed
  {
    logic [4:0] code;
    logic       rp;
    logic [4:0] exp_atten;
    logic       exp_lp;
  } row_t;

  logic              core_clk;
  logic              resetn;
  host_pins_t        pins;
  logic              sdo;
  logic              sdo_oe;
  logic              sdo_line;
  logic              low_power;
  logic              active;
  logic [GAIN_W-1:0] atten;
  logic [7:0]        rd;
  logic              oe_seen = 1'b0;
  int                fails = 0;
  int                num_checks = 0;
  int                cyc = 0;
  row_t              rows [6] = '{'{5'h00, 1'b0, 5'h00, 1'b0}, '{5'h01, 1'b1, 5'h01, 1'b1},
                                  '{5'h0f, 1'b0, 5'h0f, 1'b0}, '{5'h10, 1'b1, 5'h10, 1'b1},
                                  '{5'h1e, 1'b0, 5'h1e, 1'b0}, '{5'h1f, 1'b1, 5'h1f, 1'b1}};

  // clock, 5 ns period
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  // weak pull-down on the board, so a released line reads low
  assign sdo_line = sdo_oe & sdo;

  gain_power_control_port u_dut
  (
    .core_clk_i   (core_clk),
    .resetn_i     (resetn),
    .pins_i       (pins),
    .sdo_o        (sdo),
    .sdo_oe_o     (sdo_oe),
    .atten_code_o (atten),
    .low_power_o  (low_power),
    .active_o     (active)
  );

  host_model u_host
  (
    .core_clk_i (core_clk),
    .sdo_i      (sdo_line),
    .pins_o     (pins)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog, plus a flag for serial output activity in parallel mode
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (sdo_oe && pins.parallel_select)
      oe_seen <= 1'b1;
    if (cyc > 50000)
    begin
      fails++;
      close_out();
    end
  end

  initial
  begin
    resetn = 1'b0;
    repeat (9) @(posedge core_clk);
    @(negedge core_clk);
    check({atten, low_power, active, sdo_oe}, 8'h00);
    @(posedge core_clk);
    resetn <= 1'b1;
    u_host.mode(1'b1, 1'b1, 1'b0);
    @(negedge core_clk);
    check({7'h0, active}, 8'h01);
    $display("reset test done");
    // parallel codes across the range with the low power pin
    foreach (rows[i])
    begin
      u_host.mode(1'b1, 1'b1, rows[i].rp);
      u_host.latch_code(rows[i].code);
      @(negedge core_clk);
      check({3'h0, atten}, {3'h0, rows[i].exp_atten});
      check({7'h0, low_power}, {7'h0, rows[i].exp_lp});
    end
    $display("parallel rows done");
    // serial control, gain pins left at 1f and ignored
    u_host.mode(1'b1, 1'b0, 1'b0);
    @(negedge core_clk);
    check({3'h0, atten}, 8'h00);
    u_host.frame({1'b0, REG_GAIN, 8'h15}, rd);
    @(negedge core_clk);
    check({3'h0, atten}, 8'h15);
    u_host.frame({1'b1, REG_GAIN, 8'h00}, rd);
    check(rd, 8'h15);
    @(negedge core_clk);
    check({7'h0, sdo_oe}, 8'h00);
    u_host.frame({1'b0, REG_POWER, 8'h01}, rd);
    @(negedge core_clk);
    check({7'h0, low_power}, 8'h01);
    u_host.frame({1'b1, REG_GAIN, 8'h00}, rd);
    check(rd, 8'h15);
    u_host.frame({1'b1, REG_POWER, 8'h00}, rd);
    check(rd, 8'h01);
    u_host.frame({1'b0, REG_POWER, 8'h00}, rd);
    @(negedge core_clk);
    check({7'h0, low_power}, 8'h00);
    u_host.frame({1'b0, 7'h05, 8'h1b}, rd);
    u_host.frame({1'b1, 7'h05, 8'h00}, rd);
    check(rd, 8'h00);
    $display("serial test done");
    // serial port silent while parallel select is high
    u_host.mode(1'b1, 1'b1, 1'b0);
    u_host.frame({1'b1, REG_GAIN, 8'h03}, rd);
    u_host.frame({1'b0, REG_GAIN, 8'h03}, rd);
    @(negedge core_clk);
    check({3'h0, atten}, 8'h1f);
    u_host.mode(1'b1, 1'b0, 1'b0);
    @(negedge core_clk);
    check({3'h0, atten}, 8'h15);
    check({7'h0, oe_seen}, 8'h00);
    // disabled device refuses serial writes
    u_host.mode(1'b0, 1'b0, 1'b0);
    @(negedge core_clk);
    check({7'h0, active}, 8'h00);
    u_host.frame({1'b0, REG_GAIN, 8'h0a}, rd);
    u_host.mode(1'b1, 1'b0, 1'b0);
    @(negedge core_clk);
    check({3'h0, atten}, 8'h15);
    $display("mode test done");
    // second reset in mid-run
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check({atten, low_power, active, sdo_oe}, 8'h00);
    @(posedge core_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    check({7'h0, active}, 8'h01);
    check({3'h0, atten}, 8'h00);
    $display("mid-run reset test done");
    close_out();
  end
endmodule
